// [smt_consts.svh]
// Register offsets, field positions and reset values of the measurement timer.
`ifndef SMT_CONSTS_SVH
`define SMT_CONSTS_SVH
`define SMT_OFS_CTRL0 12'h000
`define SMT_OFS_CTRL1 12'h004
`define SMT_OFS_STATUS 12'h008
`define SMT_OFS_CLKSEL 12'h00c
`define SMT_OFS_SIGSEL 12'h010
`define SMT_OFS_WINSEL 12'h014
`define SMT_OFS_COUNT 12'h018
`define SMT_OFS_PERIOD 12'h01c
`define SMT_OFS_WIDTH 12'h020
`define SMT_OFS_PCAP 12'h024
`define SMT_OFS_IRQFLAG 12'h028
`define SMT_OFS_IRQEN 12'h02c
`define SMT_C0_EN 7
`define SMT_C0_STP 5
`define SMT_C0_WINV 4
`define SMT_C0_SINV 3
`define SMT_C0_CINV 2
`define SMT_C1_GO 7
`define SMT_C1_REPEAT 6
`define SMT_ST_PERIOD_CAPTURE_UPDATE_REQUEST 7
`define SMT_ST_WIDTH_CAPTURE_UPDATE_REQUEST 6
`define SMT_ST_RST 4
`define SMT_ST_TS 2
`define SMT_ST_WS 1
`define SMT_ST_AS 0
`define SMT_IRQ_MATCH 0
`define SMT_IRQ_WIDTH 1
`define SMT_IRQ_PERIOD 2
`define SMT_RST_COUNT 24'h000000
`define SMT_RST_PERIOD 24'hffffff
`define SMT_COUNT_ONE 24'h000001
`endif

// [smt_pkg.sv]
// Types shared by the signal measurement timer.
package smt_pkg;
  typedef enum logic [3:0] {
    SMT_TIMER = 4'b0000,
    SMT_GATED_TIMER = 4'b0001,
    SMT_PERIOD_DUTY = 4'b0010,
    SMT_HIGH_LOW = 4'b0011,
    SMT_WINDOWED = 4'b0100,
    SMT_GATED_WINDOW = 4'b0101,
    SMT_TIME_OF_FLIGHT = 4'b0110,
    SMT_CAPTURE = 4'b0111,
    SMT_COUNTER = 4'b1000,
    SMT_GATED_COUNTER = 4'b1001,
    SMT_WINDOWED_COUNTER = 4'b1010
  } smt_mode_type;

  typedef struct packed {
    logic en;
    logic stop_at_period;
    logic window_invert;
    logic signal_invert;
    logic clock_invert;
    logic [1:0] prescale_select;
  } smt_ctrl_type;
endpackage

// [smt_src_model.sv]
// Model of the on-chip clock, signal and window sources feeding the timer.
`timescale 1ns/1ns
module smt_src_model (
  // Clock, reset and levels chosen by the bench.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sig_lvl,
  input wire logic win_lvl,
  // Candidate sources.
  output logic [7:0] clock_sources,
  output logic [31:0] signal_sources,
  output logic [31:0] window_sources
);
  logic [1:0] div_r;
  logic [30:0] noise_r;
  // Unselected sources toggle every cycle so a wrong select shows up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
      noise_r <= 31'h0;
    end else begin
      div_r <= div_r + 2'h1;
      noise_r <= ~noise_r;
    end
  end
  assign clock_sources = {noise_r[6:0], div_r[1]};
  assign signal_sources = {noise_r, sig_lvl};
  assign window_sources = {~noise_r, win_lvl};
endmodule

// [smt_top.sv]
// Signal measurement timer with its APB register file.
// Notes on behaviour
// [RQ1] 24-bit counter runs on the prescaled clock, which also paces input sampling; the three counter modes step on every bus clock instead.
// [RQ2] Software may invert the selected clock source before the counter uses it.
// [RQ3] Signal and window inputs each have their own software inversion.
// [RQ4] Writing the clear bit in status zeroes the counter.
// [RQ5] At period value the counter holds if stop-at-period, otherwise wraps to zero.
// [RQ6] Capture update bits copy the counter into width or period capture.
// [RQ7] Run flag follows run request through synchroniser delay, except in the three counter modes.
// [RQ8] Status shows the synchronised corrected signal level.
// [RQ9] Status shows the synchronised corrected window level.
// [RQ10] Single acquisition stops and clears run request; repeat keeps overwriting.
// [RQ11] Timer mode counts while running and ignores signal and window.
// [RQ12] Gated timer counts while signal high; width captured on signal fall.
// [RQ13] Period/duty: width on fall; period on rise, counter set to one.
// [RQ14] High/low: start on rise; fall captures width and resets; rise captures period.
// [RQ15] Windowed: start on window rise; next window rise captures period and resets.
// [RQ16] Gated window: count while signal high; later window rises capture period.
// [RQ17] Time of flight: window rise starts, signal rise captures period; repeat window width.
// [RQ18] Capture: free count; window rise captures period, window fall captures width.
// [RQ19] Counter: count signal pulses; window fall captures width.
// [RQ20] Gated counter: count pulses from window rise; window fall captures width.
// [RQ21] Windowed counter: window fall captures width, later window rises capture period.
// [RQ22] Width, period and match events set flags, each with its own enable.
// [RQ23] A mode field in the second control register selects among the eleven modes.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`include "smt_consts.svh"
module smt_top
  import smt_pkg::*;
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Source candidates from the rest of the chip.
  input wire logic [7:0] clock_sources,
  input wire logic [31:0] signal_sources,
  input wire logic [31:0] window_sources,
  // Interrupt requests, each gated by its enable.
  output logic width_capture_irq,
  output logic period_capture_irq,
  output logic period_match_irq
);
  smt_ctrl_type ctrl_r;
  smt_mode_type mode_r;
  logic run_request_r;
  logic repeat_r;
  logic [2:0] clock_source_select_r;
  logic [4:0] signal_source_select_r;
  logic [4:0] window_source_select_r;
  logic [23:0] count_value_r;
  logic [23:0] period_match_value_r;
  logic [23:0] pulse_width_capture_r;
  logic [23:0] period_capture_r;
  logic [2:0] irq_flag_r;
  logic [2:0] irq_enable_r;
  logic [2:0] sync1_r, sync2_r, sync3_r, filt_r;
  logic [2:0] raw_in;
  logic clk_prev_r;
  logic [2:0] pre_cnt_r;
  logic [2:0] pre_mask;
  logic clk_edge, tick, step, counter_like;
  logic sig_q_r, sig_prev_r, win_q_r, win_prev_r;
  logic sig_rise, sig_fall, win_rise, win_fall;
  logic go_sync_r, run_state_r, running;
  logic armed_r, armed_nxt;
  logic [23:0] count_nxt;
  logic inc, cnt_load, cpw_load, cpr_load, acq_done;
  logic at_period, match_evt;
  logic wr, rd_setup, addr_ok, wr_status, wr_count;

  // Bus decode. Zero wait states; unmapped offsets answer with an error.
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  always_comb begin
    unique case (paddr)
      `SMT_OFS_CTRL0, `SMT_OFS_CTRL1, `SMT_OFS_STATUS, `SMT_OFS_CLKSEL,
      `SMT_OFS_SIGSEL, `SMT_OFS_WINSEL, `SMT_OFS_COUNT, `SMT_OFS_PERIOD,
      `SMT_OFS_WIDTH, `SMT_OFS_PCAP, `SMT_OFS_IRQFLAG,
      `SMT_OFS_IRQEN: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_status = wr & (paddr == `SMT_OFS_STATUS);
  assign wr_count = wr & (paddr == `SMT_OFS_COUNT);

  // Source selection, then three flops; a change is taken only once the
  // last two agree, which filters a level caught mid-transition.
  assign raw_in[0] = clock_sources[clock_source_select_r];
  assign raw_in[1] = signal_sources[signal_source_select_r];
  assign raw_in[2] = window_sources[window_source_select_r];
  generate
    for (genvar i = 0; i < 3; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[i] <= 1'b0;
          sync2_r[i] <= 1'b0;
          sync3_r[i] <= 1'b0;
          filt_r[i] <= 1'b0;
        end else begin
          sync1_r[i] <= raw_in[i];
          sync2_r[i] <= sync1_r[i];
          sync3_r[i] <= sync2_r[i];
          if (sync2_r[i] == sync3_r[i]) begin
            filt_r[i] <= sync3_r[i];
          end
        end
      end
    end
  endgenerate

  // Prescaled clock: one tick per 1, 2, 4 or 8 source edges.
  assign clk_edge = (filt_r[0] ^ ctrl_r.clock_invert) & ~clk_prev_r; // see [RQ2]
  assign pre_mask = 3'((4'h1 << ctrl_r.prescale_select) - 4'h1);
  assign tick = ctrl_r.en & clk_edge & (pre_cnt_r == pre_mask); // see [RQ1]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_r <= 1'b0;
      pre_cnt_r <= 3'h0;
    end else begin
      clk_prev_r <= filt_r[0] ^ ctrl_r.clock_invert;
      if (!ctrl_r.en || tick) begin
        pre_cnt_r <= 3'h0;
      end else if (clk_edge) begin
        pre_cnt_r <= pre_cnt_r + 3'h1;
      end
    end
  end

  // Counter modes take the signal itself as time base, so they step on
  // every bus clock instead of on the prescaled tick.
  assign counter_like = (mode_r == SMT_COUNTER) ||
                        (mode_r == SMT_GATED_COUNTER) ||
                        (mode_r == SMT_WINDOWED_COUNTER);
  assign step = counter_like ? ctrl_r.en : tick; // see [RQ19]

  // Input sampling and run-state pipeline on the step. see [RQ1] [RQ3]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_q_r <= 1'b0;
      sig_prev_r <= 1'b0;
      win_q_r <= 1'b0;
      win_prev_r <= 1'b0;
      go_sync_r <= 1'b0;
      run_state_r <= 1'b0;
    end else if (step) begin
      sig_q_r <= filt_r[1] ^ ctrl_r.signal_invert;
      sig_prev_r <= sig_q_r;
      win_q_r <= filt_r[2] ^ ctrl_r.window_invert;
      win_prev_r <= win_q_r;
      go_sync_r <= run_request_r;
      run_state_r <= go_sync_r; // see [RQ7]
    end
  end
  assign running = counter_like ? run_request_r : run_state_r; // see [RQ7]
  assign sig_rise = sig_q_r & ~sig_prev_r;
  assign sig_fall = ~sig_q_r & sig_prev_r;
  assign win_rise = win_q_r & ~win_prev_r;
  assign win_fall = ~win_q_r & win_prev_r;
  assign at_period = (count_value_r == period_match_value_r);

  // Mode behaviour: decides increment, reload and captures for one step.
  always_comb begin
    inc = 1'b0;
    cnt_load = 1'b0;
    count_nxt = `SMT_RST_COUNT;
    cpw_load = 1'b0;
    cpr_load = 1'b0;
    acq_done = 1'b0;
    armed_nxt = armed_r;
    unique case (mode_r) // see [RQ23]
      SMT_TIMER: inc = 1'b1; // see [RQ11]
      SMT_GATED_TIMER: begin
        inc = sig_q_r; // see [RQ12]
        cpw_load = sig_fall;
        acq_done = sig_fall;
      end
      SMT_PERIOD_DUTY: begin
        inc = 1'b1; // see [RQ13]
        cpw_load = sig_fall;
        if (sig_rise) begin
          cpr_load = 1'b1;
          cnt_load = 1'b1;
          count_nxt = `SMT_COUNT_ONE;
          acq_done = 1'b1;
        end
      end
      SMT_HIGH_LOW: begin
        inc = armed_r; // see [RQ14]
        if (!armed_r) begin
          armed_nxt = sig_rise;
          cnt_load = sig_rise;
        end else if (sig_fall) begin
          cpw_load = 1'b1;
          cnt_load = 1'b1;
        end else if (sig_rise) begin
          cpr_load = 1'b1;
          cnt_load = 1'b1;
          acq_done = 1'b1;
        end
      end
      SMT_WINDOWED, SMT_GATED_WINDOW: begin
        inc = armed_r & ((mode_r == SMT_WINDOWED) | sig_q_r); // see [RQ16]
        if (win_rise) begin
          armed_nxt = 1'b1; // see [RQ15]
          cnt_load = 1'b1;
          cpr_load = armed_r;
          acq_done = armed_r;
        end
      end
      SMT_TIME_OF_FLIGHT: begin
        inc = armed_r; // see [RQ17]
        if (win_rise) begin
          armed_nxt = 1'b1;
          cnt_load = 1'b1;
          cpw_load = armed_r;
        end else if (armed_r && sig_rise) begin
          armed_nxt = 1'b0;
          cnt_load = 1'b1;
          cpr_load = 1'b1;
          acq_done = 1'b1;
        end
      end
      SMT_CAPTURE: begin
        inc = 1'b1; // see [RQ18]
        cpr_load = win_rise;
        cpw_load = win_fall;
        acq_done = win_rise;
      end
      SMT_COUNTER: begin
        inc = sig_rise; // see [RQ19]
        cpw_load = win_fall;
        acq_done = win_fall;
      end
      SMT_GATED_COUNTER: begin
        inc = armed_r & win_q_r & sig_rise; // see [RQ20]
        if (win_rise) begin
          armed_nxt = 1'b1;
        end else if (armed_r && win_fall) begin
          armed_nxt = 1'b0;
          cpw_load = 1'b1;
          acq_done = 1'b1;
        end
      end
      SMT_WINDOWED_COUNTER: begin
        inc = armed_r & sig_rise; // see [RQ21]
        if (win_rise) begin
          armed_nxt = 1'b1;
          cnt_load = armed_r;
          cpr_load = armed_r;
          acq_done = armed_r;
        end
        cpw_load = armed_r & win_fall;
      end
      default: inc = 1'b1;
    endcase
    if (!(step && running && run_request_r)) begin // see [RQ10]
      inc = 1'b0;
      cnt_load = 1'b0;
      cpw_load = 1'b0;
      cpr_load = 1'b0;
      acq_done = 1'b0;
      armed_nxt = running & armed_r;
    end
  end
  assign match_evt = inc & ~cnt_load & at_period;

  // Counter: software clear first, then software write, then hardware.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_r <= `SMT_RST_COUNT;
    end else if (wr_status && pwdata[`SMT_ST_RST]) begin
      count_value_r <= `SMT_RST_COUNT; // see [RQ4]
    end else if (wr_count) begin
      count_value_r <= pwdata[23:0];
    end else if (cnt_load) begin
      count_value_r <= count_nxt;
    end else if (match_evt) begin
      if (!ctrl_r.stop_at_period) begin
        count_value_r <= `SMT_RST_COUNT; // see [RQ5] [RQ11]
      end
    end else if (inc) begin
      count_value_r <= count_value_r + `SMT_COUNT_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= armed_nxt;
    end
  end

  // Capture registers; software update requests act like hardware loads.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_width_capture_r <= `SMT_RST_COUNT;
      period_capture_r <= `SMT_RST_COUNT;
    end else begin
      if (cpw_load || (wr_status && pwdata[`SMT_ST_WIDTH_CAPTURE_UPDATE_REQUEST])) begin
        pulse_width_capture_r <= count_value_r; // see [RQ6]
      end
      if (cpr_load || (wr_status && pwdata[`SMT_ST_PERIOD_CAPTURE_UPDATE_REQUEST])) begin
        period_capture_r <= count_value_r; // see [RQ6]
      end
    end
  end

  // Interrupt flags: hardware set wins over a write-one-to-clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_r <= 3'h0;
    end else begin
      if (wr && paddr == `SMT_OFS_IRQFLAG) begin
        irq_flag_r <= irq_flag_r & ~pwdata[2:0];
      end
      if (match_evt) begin
        irq_flag_r[`SMT_IRQ_MATCH] <= 1'b1; // see [RQ22]
      end
      if (cpw_load) begin
        irq_flag_r[`SMT_IRQ_WIDTH] <= 1'b1; // see [RQ22]
      end
      if (cpr_load) begin
        irq_flag_r[`SMT_IRQ_PERIOD] <= 1'b1; // see [RQ22]
      end
    end
  end
  assign period_match_irq = irq_flag_r[`SMT_IRQ_MATCH] &
                            irq_enable_r[`SMT_IRQ_MATCH];
  assign width_capture_irq = irq_flag_r[`SMT_IRQ_WIDTH] &
                             irq_enable_r[`SMT_IRQ_WIDTH];
  assign period_capture_irq = irq_flag_r[`SMT_IRQ_PERIOD] &
                              irq_enable_r[`SMT_IRQ_PERIOD];

  // Control registers. A completed single acquisition drops the run
  // request, and it overrides a software write in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= '0;
      mode_r <= SMT_TIMER;
      run_request_r <= 1'b0;
      repeat_r <= 1'b0;
      clock_source_select_r <= 3'h0;
      signal_source_select_r <= 5'h00;
      window_source_select_r <= 5'h00;
      period_match_value_r <= `SMT_RST_PERIOD;
      irq_enable_r <= 3'h0;
    end else begin
      if (wr) begin
        unique case (paddr)
          `SMT_OFS_CTRL0: ctrl_r <= {pwdata[`SMT_C0_EN],
                                     pwdata[`SMT_C0_STP:`SMT_C0_CINV],
                                     pwdata[1:0]};
          `SMT_OFS_CTRL1: begin
            run_request_r <= pwdata[`SMT_C1_GO];
            repeat_r <= pwdata[`SMT_C1_REPEAT];
            mode_r <= smt_mode_type'(pwdata[3:0]); // see [RQ23]
          end
          `SMT_OFS_CLKSEL: clock_source_select_r <= pwdata[2:0];
          `SMT_OFS_SIGSEL: signal_source_select_r <= pwdata[4:0];
          `SMT_OFS_WINSEL: window_source_select_r <= pwdata[4:0];
          `SMT_OFS_PERIOD: period_match_value_r <= pwdata[23:0];
          `SMT_OFS_IRQEN: irq_enable_r <= pwdata[2:0];
          default: ;
        endcase
      end
      if (acq_done && !repeat_r) begin
        run_request_r <= 1'b0; // see [RQ10]
      end
    end
  end

  // Read data is taken in the setup phase and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        `SMT_OFS_CTRL0: prdata <= {24'h0, ctrl_r.en, 1'b0,
                                   ctrl_r[5:0]};
        `SMT_OFS_CTRL1: prdata <= {24'h0, run_request_r, repeat_r,
                                   2'h0, mode_r};
        `SMT_OFS_STATUS: prdata <= {29'h0, running, win_q_r,
                                    sig_q_r}; // see [RQ8] [RQ9]
        `SMT_OFS_CLKSEL: prdata <= {29'h0, clock_source_select_r};
        `SMT_OFS_SIGSEL: prdata <= {27'h0, signal_source_select_r};
        `SMT_OFS_WINSEL: prdata <= {27'h0, window_source_select_r};
        `SMT_OFS_COUNT: prdata <= {8'h0, count_value_r};
        `SMT_OFS_PERIOD: prdata <= {8'h0, period_match_value_r};
        `SMT_OFS_WIDTH: prdata <= {8'h0, pulse_width_capture_r};
        `SMT_OFS_PCAP: prdata <= {8'h0, period_capture_r};
        `SMT_OFS_IRQFLAG: prdata <= {29'h0, irq_flag_r};
        `SMT_OFS_IRQEN: prdata <= {29'h0, irq_enable_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks.
  sequence s_clear_req;
    wr_status && pwdata[`SMT_ST_RST];
  endsequence
  sequence s_hw_wrap;
    match_evt && !wr_status && !wr_count;
  endsequence
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      s_clear_req |=> count_value_r == `SMT_RST_COUNT;
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed"); // see [RQ4]
  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
      s_hw_wrap ##0 !ctrl_r.stop_at_period |=> count_value_r == 24'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap"); // see [RQ5]
  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      s_hw_wrap ##0 ctrl_r.stop_at_period |=>
        count_value_r == $past(period_match_value_r);
  endproperty
  a_hold: assert property (p_hold) else $error("no hold"); // see [RQ5]
  property p_width_capture_update_request;
    @(posedge pclk) disable iff (!presetn)
      wr_status && pwdata[`SMT_ST_WIDTH_CAPTURE_UPDATE_REQUEST] |=>
        pulse_width_capture_r == $past(count_value_r);
  endproperty
  a_width_capture_update_request: assert property (p_width_capture_update_request) else $error("cpw update"); // see [RQ6]
  property p_single;
    @(posedge pclk) disable iff (!presetn)
      acq_done && !repeat_r |=> !run_request_r;
  endproperty
  a_single: assert property (p_single) else $error("single run"); // see [RQ10]
  property p_match_flag;
    @(posedge pclk) disable iff (!presetn)
      match_evt |=> irq_flag_r[`SMT_IRQ_MATCH];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("flag"); // see [RQ22]
  property p_pd_one;
    @(posedge pclk) disable iff (!presetn)
      mode_r == SMT_PERIOD_DUTY && cpr_load && !wr_status && !wr_count
        |=> count_value_r == `SMT_COUNT_ONE && period_capture_r != 24'h0
            || $past(count_value_r) == 24'h0;
  endproperty
  a_pd_one: assert property (p_pd_one) else $error("pd reload"); // see [RQ13]
  property p_ts;
    @(posedge pclk) disable iff (!presetn)
      !counter_like && $rose(run_state_r) |-> $past(go_sync_r);
  endproperty
  a_ts: assert property (p_ts) else $error("run flag"); // see [RQ7]
  property p_filter;
    @(posedge pclk) disable iff (!presetn)
      $changed(filt_r[1]) |-> $past(sync2_r[1] == sync3_r[1]);
  endproperty
  a_filter: assert property (p_filter) else $error("filter"); // see [RQ3]
endmodule

// [tb.sv]
// Self-checking bench for the signal measurement timer.
`timescale 1ns/1ns
`include "smt_consts.svh"
module tb;
  import smt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic sig_lvl, win_lvl, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, wv;
  logic [7:0] clock_sources;
  logic [31:0] signal_sources, window_sources;
  logic width_capture_irq, period_capture_irq, period_match_irq;
  int num_errors = 0;
  int samples_checked = 0;
  smt_top smt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_sources(clock_sources), .signal_sources(signal_sources),
    .window_sources(window_sources), .width_capture_irq(width_capture_irq),
    .period_capture_irq(period_capture_irq),
    .period_match_irq(period_match_irq));
  smt_src_model smt_src_model_inst (.pclk(pclk), .presetn(presetn),
    .sig_lvl(sig_lvl), .win_lvl(win_lvl), .clock_sources(clock_sources),
    .signal_sources(signal_sources), .window_sources(window_sources));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      num_errors++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads until the masked field matches, since input paths add latency.
  task automatic poll(input string name, input logic [11:0] a,
                      input logic [31:0] m, e);
    int n;
    n = 0;
    do begin
      apb(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== e && n < 200);
    chk(name, e, rd & m);
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Drives whole signal pulses; each one ends with a rising edge.
  task automatic pulses(input int n);
    repeat (n) begin
      sig_lvl <= 1'b0;
      hold(8);
      sig_lvl <= 1'b1;
      hold(8);
    end
  endtask
  initial begin
    #80000;
    num_errors++;
    complete_run();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sig_lvl = 1'b0;
    win_lvl = 1'b0;
    hold(2);
    presetn <= 1'b1;
    apb(1'b0, `SMT_OFS_PERIOD, 32'h0);
    chk("period reset", 32'h00ffffff, rd);
    apb(1'b0, `SMT_OFS_COUNT, 32'h0);
    chk("count reset", 32'h0, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, `SMT_OFS_COUNT, 32'h00abcdef);
    apb(1'b1, `SMT_OFS_STATUS, 32'h40);
    apb(1'b1, `SMT_OFS_STATUS, 32'h80);
    apb(1'b0, `SMT_OFS_WIDTH, 32'h0);
    chk("width update", 32'h00abcdef, rd);
    apb(1'b0, `SMT_OFS_PCAP, 32'h0);
    chk("period update", 32'h00abcdef, rd);
    apb(1'b1, `SMT_OFS_STATUS, 32'h10);
    apb(1'b0, `SMT_OFS_COUNT, 32'h0);
    chk("count clear", 32'h0, rd);
    // Timer mode holding at the period value.
    apb(1'b1, `SMT_OFS_PERIOD, 32'h5);
    apb(1'b1, `SMT_OFS_IRQEN, 32'h7);
    apb(1'b1, `SMT_OFS_CTRL0, 32'ha0);
    apb(1'b1, `SMT_OFS_CTRL1, 32'hc0);
    poll("count held", `SMT_OFS_COUNT, 32'hffffffff, 32'h5);
    hold(40);
    apb(1'b0, `SMT_OFS_COUNT, 32'h0);
    chk("count still held", 32'h5, rd);
    chk("match irq", 32'h1, {31'h0, period_match_irq});
    apb(1'b0, `SMT_OFS_IRQFLAG, 32'h0);
    chk("match flag", 32'h1, rd & 32'h1);
    poll("run flag", `SMT_OFS_STATUS, 32'h4, 32'h4);
    sig_lvl <= 1'b1;
    poll("signal level", `SMT_OFS_STATUS, 32'h1, 32'h1);
    apb(1'b1, `SMT_OFS_CTRL0, 32'ha8);
    poll("signal inverted", `SMT_OFS_STATUS, 32'h1, 32'h0);
    win_lvl <= 1'b1;
    apb(1'b1, `SMT_OFS_CTRL0, 32'ha0);
    poll("window level", `SMT_OFS_STATUS, 32'h2, 32'h2);
    apb(1'b1, `SMT_OFS_CTRL0, 32'hb0);
    poll("window inverted", `SMT_OFS_STATUS, 32'h2, 32'h0);
    // Without stop-at-period the count wraps and never passes the period.
    apb(1'b1, `SMT_OFS_CTRL0, 32'h80);
    ok = 1'b1;
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, `SMT_OFS_COUNT, 32'h0);
      ok = ok & (rd <= 32'h5);
    end
    chk("count wraps", 32'h1, {31'h0, ok});
    // Period and duty, single acquisition: fall then rise 6 ticks apart.
    apb(1'b1, `SMT_OFS_CTRL1, 32'h0);
    apb(1'b1, `SMT_OFS_PERIOD, 32'h00ffffff);
    apb(1'b1, `SMT_OFS_IRQFLAG, 32'h7);
    apb(1'b1, `SMT_OFS_CTRL1, 32'h82);
    poll("running high", `SMT_OFS_STATUS, 32'h5, 32'h5);
    hold(24);
    sig_lvl <= 1'b0;
    hold(24);
    sig_lvl <= 1'b1;
    poll("single done", `SMT_OFS_CTRL1, 32'h80, 32'h0);
    apb(1'b0, `SMT_OFS_WIDTH, 32'h0);
    wv = rd;
    apb(1'b0, `SMT_OFS_PCAP, 32'h0);
    chk("low time", 32'h6, rd - wv);
    chk("period irq", 32'h1, {31'h0, period_capture_irq});
    chk("width irq", 32'h1, {31'h0, width_capture_irq});
    apb(1'b0, `SMT_OFS_COUNT, 32'h0);
    wv = rd;
    hold(40);
    apb(1'b0, `SMT_OFS_COUNT, 32'h0);
    chk("stopped count", wv, rd);
    // Counter mode: five signal pulses, window fall captures them.
    win_lvl <= 1'b1;
    apb(1'b1, `SMT_OFS_STATUS, 32'h10);
    apb(1'b1, `SMT_OFS_CTRL1, 32'h88);
    pulses(5);
    hold(24);
    win_lvl <= 1'b0;
    poll("pulse count", `SMT_OFS_WIDTH, 32'hffffffff, 32'h5);
    // Gated timer: six prescaled clocks of signal high become the width.
    sig_lvl <= 1'b0;
    apb(1'b1, `SMT_OFS_STATUS, 32'h10);
    apb(1'b1, `SMT_OFS_CTRL1, 32'h81);
    poll("gated run", `SMT_OFS_STATUS, 32'h4, 32'h4);
    sig_lvl <= 1'b1;
    hold(24);
    sig_lvl <= 1'b0;
    poll("gated width", `SMT_OFS_WIDTH, 32'hffffffff, 32'h6);
    // High/low: high for eight clocks, low for four, measured alike.
    hold(16);
    apb(1'b1, `SMT_OFS_CTRL1, 32'h83);
    poll("hl run", `SMT_OFS_STATUS, 32'h4, 32'h4);
    sig_lvl <= 1'b1;
    hold(32);
    sig_lvl <= 1'b0;
    hold(16);
    sig_lvl <= 1'b1;
    poll("hl done", `SMT_OFS_CTRL1, 32'h80, 32'h0);
    apb(1'b0, `SMT_OFS_WIDTH, 32'h0);
    wv = rd;
    apb(1'b0, `SMT_OFS_PCAP, 32'h0);
    chk("high minus low", 32'h4, wv - rd);
    // Capture: a window high for six clocks separates the two captures.
    hold(16);
    apb(1'b1, `SMT_OFS_CTRL1, 32'hc7);
    poll("cap run", `SMT_OFS_STATUS, 32'h4, 32'h4);
    win_lvl <= 1'b1;
    hold(24);
    win_lvl <= 1'b0;
    hold(24);
    apb(1'b0, `SMT_OFS_WIDTH, 32'h0);
    wv = rd;
    apb(1'b0, `SMT_OFS_PCAP, 32'h0);
    chk("window high", 32'h6, wv - rd);
    // Gated counter: pulses before the window opens are not counted.
    apb(1'b1, `SMT_OFS_CTRL1, 32'h89);
    apb(1'b1, `SMT_OFS_STATUS, 32'h10);
    pulses(2);
    win_lvl <= 1'b1;
    hold(8);
    pulses(3);
    win_lvl <= 1'b0;
    poll("gated count", `SMT_OFS_WIDTH, 32'hffffffff, 32'h3);
    complete_run();
  end
endmodule
